// [hdl/smr_line_if.sv]
// Purpose: Cleaned bus lines and bus conditions between modules
// Assumes: All signals on sys_clk
// Notes: Producer is the line synchroniser
`timescale 1ns/1ps
interface smr_line_if;
    import smr_pkg::*;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic [SMR_AUX_W-1:0] aux;
    modport src (output scl, sda, scl_rise, scl_fall, start, stop, aux);
    modport dst (input scl, sda, scl_rise, scl_fall, start, stop, aux);
endinterface

// [hdl/smr_line_sync.sv]
// Purpose: Synchronise bus and strap pins, detect edges and conditions
// Assumes: Pins are asynchronous to sys_clk
// Notes: A level changes once stages two and three agree
`timescale 1ns/1ps
module smr_line_sync
    import smr_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic reset, // Async reset, active high
    input wire logic scl_pin, // Raw bus clock
    input wire logic sda_pin, // Raw bus data
    input wire logic [SMR_AUX_W-1:0] aux_pin, // Raw strap and id pins
    smr_line_if.src line // Cleaned lines and conditions
);
    localparam int W = 2 + SMR_AUX_W;
    logic [W-1:0] s1_q, s2_q, s3_q, clean_q, clean_d;
    logic rise_q, fall_q, start_q, stop_q;
    logic rise_d, fall_d, start_d, stop_d;

    // Accept a new level only when the last two stages agree
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            clean_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : clean_q[i];
        end
        rise_d = clean_d[0] & ~clean_q[0];
        fall_d = ~clean_d[0] & clean_q[0];
        // Data moving while the clock stays high marks start or stop
        start_d = clean_q[0] & clean_d[0] & clean_q[1]
            & ~clean_d[1];
        stop_d = clean_q[0] & clean_d[0] & ~clean_q[1]
            & clean_d[1];
    end

    // Idle bus reads high, so lines reset high to avoid a false condition
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
            clean_q <= '1;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            start_q <= 1'b0;
            stop_q <= 1'b0;
        end
        else
        begin
            s1_q <= {aux_pin, sda_pin, scl_pin};
            s2_q <= s1_q;
            s3_q <= s2_q;
            clean_q <= clean_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
            start_q <= start_d;
            stop_q <= stop_d;
        end
    end

    assign line.scl = clean_q[0];
    assign line.sda = clean_q[1];
    assign line.aux = clean_q[W-1:2];
    assign line.scl_rise = rise_q;
    assign line.scl_fall = fall_q;
    assign line.start = start_q;
    assign line.stop = stop_q;
endmodule

// [hdl/smr_pkg.sv]
// Purpose: Shared constants and types for the management bus slave
// Assumes: 10 MHz system clock, one clock domain
// Notes: Register contents live outside; only the pointer is held here
package smr_pkg;
    // Fixed upper address bits; the low two come from the strap pin
    localparam logic [4:0] SMR_ADDR_FIXED = 5'h0B;
    // Strap decode of the three-state pin into the low address bits
    localparam logic [1:0] SMR_STRAP_GND = 2'h0;
    localparam logic [1:0] SMR_STRAP_OPEN = 2'h2;
    localparam logic [1:0] SMR_STRAP_VCC = 2'h1;
    // Byte framing
    localparam int SMR_DATA_W = 8;
    localparam int SMR_PTR_W = 8;
    localparam int SMR_CNT_W = 4;
    localparam logic [3:0] SMR_LAST_BIT = 4'h7;
    localparam logic [3:0] SMR_CNT_ZERO = 4'h0;
    localparam logic [3:0] SMR_CNT_ONE = 4'h1;
    // Write byte index: first byte loads the pointer, second the data
    localparam logic [1:0] SMR_WR_PTR_BYTE = 2'h0;
    localparam logic [1:0] SMR_WR_DATA_BYTE = 2'h1;
    localparam logic [1:0] SMR_WR_IDX_ONE = 2'h1;
    // Direction bit values
    localparam logic SMR_DIR_WRITE = 1'b0;
    localparam logic SMR_DIR_READ = 1'b1;
    // Input synchroniser depth and aux pin count (pull-up, pull-down, id4)
    localparam int SMR_SYNC_STAGES = 3;
    localparam int SMR_AUX_W = 3;
    localparam int SMR_AUX_PU = 0;
    localparam int SMR_AUX_PD = 1;
    localparam int SMR_AUX_ID4 = 2;
    // Reset pulse length
    localparam int SMR_CLK_HZ = 10_000_000;
    localparam int SMR_RST_PULSE_MS = 20;
    localparam int SMR_RST_PULSE_CYC =
        (SMR_RST_PULSE_MS * SMR_CLK_HZ + 999) / 1000;
    localparam int SMR_RST_CNT_W = 18;

    // Slave protocol states, one-hot
    typedef enum logic [7:0] {
        SMR_IDLE    = 8'h01,
        SMR_ADDR    = 8'h02,
        SMR_ADR_ACK = 8'h04,
        SMR_WR_BYTE = 8'h08,
        SMR_WR_ACK  = 8'h10,
        SMR_RD_BYTE = 8'h20,
        SMR_RD_ACK  = 8'h40,
        SMR_IGNORE  = 8'h80
    } smr_state_type;
endpackage

// [hdl/smr_pulse_timer.sv]
// Purpose: Timed low-going reset pulse for the shared strap pin
// Assumes: Trigger is a one-cycle pulse
// Notes: A trigger during a running pulse restarts nothing
`timescale 1ns/1ps
module smr_pulse_timer
    import smr_pkg::*;
#(
    parameter int PULSE_CYC = SMR_RST_PULSE_CYC
)
(
    input wire logic sys_clk, // System clock
    input wire logic reset, // Async reset, active high
    input wire logic trigger, // Start a pulse
    output logic active // High while pulse runs
);
    logic [SMR_RST_CNT_W-1:0] cnt_q, cnt_d;
    logic active_q, active_d;

    // Count down the pulse length in system clocks
    always_comb
    begin
        cnt_d = cnt_q;
        active_d = active_q;
        if (!active_q && trigger)
        begin
            cnt_d = SMR_RST_CNT_W'(PULSE_CYC - 1);
            active_d = 1'b1;
        end
        else if (active_q)
        begin
            if (cnt_q == '0)
            begin
                active_d = 1'b0;
            end
            else
            begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            cnt_q <= '0;
            active_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            active_q <= active_d;
        end
    end

    assign active = active_q;
endmodule

// [hdl/smr_top.sv]
// Purpose: Management bus slave front end with register pointer
// Assumes: Data registers live outside and answer reads combinationally
// Notes: Strap pin doubles as reset or interrupt output
`timescale 1ns/1ps
module smr_top
    import smr_pkg::*;
#(
    parameter int RST_PULSE_CYC = SMR_RST_PULSE_CYC
)
(
    input wire logic sys_clk, // System clock, 10 MHz
    input wire logic reset, // Async reset, active high
    input wire logic scl_in, // Bus clock from master
    input wire logic sda_in, // Bus data line level
    output logic sda_out, // Data drive value, always low
    output logic sda_oe, // High while pulling data low
    input wire logic addr_pin_pu_in, // Strap pin level under weak pull-up
    input wire logic addr_pin_pd_in, // Strap pin level under weak pull-down
    output logic addr_pin_out, // Strap pin drive value, always low
    output logic addr_pin_oe, // High while strap pin pulled low
    input wire logic rst_out_enable, // Strap pin acts as reset output
    input wire logic rst_pulse_start, // One-cycle pulse request
    input wire logic int_out_enable, // Strap pin acts as interrupt output
    input wire logic limit_event, // Out-of-limit level from monitor
    input wire logic id4_digital_mode, // Pin in digital id mode
    input wire logic id4_pin_in, // Raw id bit four pin
    output logic core_volt_id_bit4, // Id bit four as read back
    output logic [SMR_PTR_W-1:0] reg_ptr, // Register pointer
    output logic reg_wr_en, // One-cycle data register write
    output logic [SMR_DATA_W-1:0] reg_wr_data, // Data to write
    input wire logic [SMR_DATA_W-1:0] reg_rd_data, // Data of pointed reg
    output logic [1:0] bus_addr_low, // Sampled low address bits
    output logic strap_done // Strap has been sampled
);
    smr_line_if line ();

    smr_state_type state_q, state_d;
    logic [SMR_CNT_W-1:0] cnt_q, cnt_d;
    logic [SMR_DATA_W-1:0] shift_q, shift_d;
    logic [1:0] wr_idx_q, wr_idx_d;
    logic [SMR_PTR_W-1:0] ptr_q, ptr_d;
    logic wr_en_q, wr_en_d;
    logic [SMR_DATA_W-1:0] wr_data_q, wr_data_d;
    logic sda_oe_q, sda_oe_d;
    logic [1:0] strap_q, strap_d;
    logic strap_done_q, strap_done_d;
    logic pin_oe_q, pin_oe_d;
    logic id4_q, id4_d;
    logic pulse_active;
    logic addr_match;

    // Three-state strap decode from the two weak-pull readings
    function automatic logic [1:0] strap_decode(input logic pu,
        input logic pd);
        logic [1:0] r;
        r = SMR_STRAP_OPEN;
        if (pu && pd)
        begin
            r = SMR_STRAP_VCC;
        end
        else if (!pu && !pd)
        begin
            r = SMR_STRAP_GND;
        end
        return r;
    endfunction

    smr_line_sync u_sync (
        .sys_clk (sys_clk),
        .reset (reset),
        .scl_pin (scl_in),
        .sda_pin (sda_in),
        .aux_pin ({id4_pin_in, addr_pin_pd_in, addr_pin_pu_in}),
        .line (line.src)
    );

    smr_pulse_timer #(
        .PULSE_CYC (RST_PULSE_CYC)
    ) u_pulse (
        .sys_clk (sys_clk),
        .reset (reset),
        .trigger (rst_pulse_start & rst_out_enable),
        .active (pulse_active)
    );

    // Full seven-bit match on the received address byte
    assign addr_match =
        (shift_q[7:1] == {SMR_ADDR_FIXED, strap_q});

    // Strap capture: only the first start after reset takes the level
    always_comb
    begin
        strap_d = strap_q;
        strap_done_d = strap_done_q;
        if (line.start && !strap_done_q)
        begin
            strap_d = strap_decode(line.aux[SMR_AUX_PU],
                line.aux[SMR_AUX_PD]);
            strap_done_d = 1'b1;
        end
    end

    // Shared pin drive and id read-back; the pin pulls low only
    always_comb
    begin
        pin_oe_d = (rst_out_enable & pulse_active) |
            (int_out_enable & limit_event);
        id4_d = id4_digital_mode & line.aux[SMR_AUX_ID4];
    end

    // Protocol engine: samples on clock rise, drives on clock fall
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        wr_idx_d = wr_idx_q;
        ptr_d = ptr_q;
        wr_en_d = 1'b0;
        wr_data_d = wr_data_q;
        sda_oe_d = sda_oe_q;
        if (line.stop)
        begin
            state_d = SMR_IDLE;
            sda_oe_d = 1'b0;
        end
        else if (line.start)
        begin
            // Repeated start also lands here, so direction is re-chosen
            state_d = SMR_ADDR;
            cnt_d = SMR_CNT_ZERO;
            sda_oe_d = 1'b0;
        end
        else
        begin
            case (state_q)
                SMR_ADDR:
                begin
                    if (line.scl_rise)
                    begin
                        shift_d = {shift_q[6:0], line.sda};
                        cnt_d = cnt_q + SMR_CNT_ONE;
                    end
                    else if (line.scl_fall && cnt_q > SMR_LAST_BIT)
                    begin
                        if (addr_match)
                        begin
                            state_d = SMR_ADR_ACK;
                            sda_oe_d = 1'b1;
                        end
                        else
                        begin
                            state_d = SMR_IGNORE;
                        end
                    end
                end
                SMR_ADR_ACK:
                begin
                    if (line.scl_fall)
                    begin
                        cnt_d = SMR_CNT_ZERO;
                        if (shift_q[0] == SMR_DIR_READ)
                        begin
                            // Load pointed register, present its MSB now
                            state_d = SMR_RD_BYTE;
                            shift_d = reg_rd_data;
                            sda_oe_d = ~reg_rd_data[7];
                        end
                        else
                        begin
                            state_d = SMR_WR_BYTE;
                            wr_idx_d = SMR_WR_PTR_BYTE;
                            sda_oe_d = 1'b0;
                        end
                    end
                end
                SMR_WR_BYTE:
                begin
                    if (line.scl_rise)
                    begin
                        shift_d = {shift_q[6:0], line.sda};
                        cnt_d = cnt_q + SMR_CNT_ONE;
                    end
                    else if (line.scl_fall && cnt_q > SMR_LAST_BIT)
                    begin
                        if (wr_idx_q == SMR_WR_PTR_BYTE)
                        begin
                            ptr_d = shift_q;
                            state_d = SMR_WR_ACK;
                            sda_oe_d = 1'b1;
                        end
                        else if (wr_idx_q == SMR_WR_DATA_BYTE)
                        begin
                            wr_en_d = 1'b1;
                            wr_data_d = shift_q;
                            state_d = SMR_WR_ACK;
                            sda_oe_d = 1'b1;
                        end
                        else
                        begin
                            // Bytes past the second are left unanswered
                            state_d = SMR_IGNORE;
                        end
                    end
                end
                SMR_WR_ACK:
                begin
                    if (line.scl_fall)
                    begin
                        // Master may now stop on the tenth clock
                        state_d = SMR_WR_BYTE;
                        sda_oe_d = 1'b0;
                        cnt_d = SMR_CNT_ZERO;
                        wr_idx_d = wr_idx_q + SMR_WR_IDX_ONE;
                    end
                end
                SMR_RD_BYTE:
                begin
                    if (line.scl_rise)
                    begin
                        cnt_d = cnt_q + SMR_CNT_ONE;
                    end
                    else if (line.scl_fall)
                    begin
                        if (cnt_q > SMR_LAST_BIT)
                        begin
                            // Release for the master's acknowledge slot
                            state_d = SMR_RD_ACK;
                            sda_oe_d = 1'b0;
                        end
                        else
                        begin
                            shift_d = {shift_q[6:0], 1'b0};
                            sda_oe_d = ~shift_q[6];
                        end
                    end
                end
                SMR_RD_ACK:
                begin
                    // One byte per read regardless of master's answer
                    if (line.scl_rise)
                    begin
                        state_d = SMR_IGNORE;
                    end
                end
                SMR_IGNORE:
                begin
                    sda_oe_d = 1'b0;
                end
                default:
                begin
                    state_d = SMR_IDLE;
                    sda_oe_d = 1'b0;
                end
            endcase
        end
    end

    // Pointer has no clear path besides reset, so it survives transfers
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= SMR_IDLE;
            cnt_q <= SMR_CNT_ZERO;
            shift_q <= '0;
            wr_idx_q <= SMR_WR_PTR_BYTE;
            ptr_q <= '0;
            wr_en_q <= 1'b0;
            wr_data_q <= '0;
            sda_oe_q <= 1'b0;
            strap_q <= SMR_STRAP_OPEN;
            strap_done_q <= 1'b0;
            pin_oe_q <= 1'b0;
            id4_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            wr_idx_q <= wr_idx_d;
            ptr_q <= ptr_d;
            wr_en_q <= wr_en_d;
            wr_data_q <= wr_data_d;
            sda_oe_q <= sda_oe_d;
            strap_q <= strap_d;
            strap_done_q <= strap_done_d;
            pin_oe_q <= pin_oe_d;
            id4_q <= id4_d;
        end
    end

    // Open-drain drive values stay low; only the enables move
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            sda_out <= 1'b0;
            addr_pin_out <= 1'b0;
        end
        else
        begin
            sda_out <= 1'b0;
            addr_pin_out <= 1'b0;
        end
    end

    assign sda_oe = sda_oe_q;
    assign addr_pin_oe = pin_oe_q;
    assign core_volt_id_bit4 = id4_q;
    assign reg_ptr = ptr_q;
    assign reg_wr_en = wr_en_q;
    assign reg_wr_data = wr_data_q;
    assign bus_addr_low = strap_q;
    assign strap_done = strap_done_q;
endmodule

// [tb/smr_master_model.sv]
// Purpose: Behavioural bus master on the far side
// Assumes: Pull-up on the data wire; clock stands high when idle
// Notes: Half period well above the slave synchroniser delay
`timescale 1ns/1ps
module smr_master_model
(
    input wire logic sys_clk, // Pacing clock
    input wire logic sda_line, // Resolved data wire
    output logic scl, // Bus clock
    output logic sda_low // High while we pull data low
);
    localparam int HALF = 10;
    logic got;
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Start, also usable as a repeated start
    task automatic start_cond();
        tick(2);
        sda_low = 1'b0;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda_low = 1'b1;
        tick(HALF);
        scl = 1'b0;
    endtask
    // Data moves only while the clock is low
    task automatic put_bit(input logic b, output logic r);
        tick(2);
        sda_low = !b;
        tick(HALF);
        scl = 1'b1;
        tick(HALF / 2);
        r = sda_line;
        tick(HALF / 2);
        scl = 1'b0;
    endtask
    // Eight bits MSB first, ninth released: slave ack or our no-ack
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
        output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(tx[i], got);
            rx[i] = got;
        end
        put_bit(1'b1, got);
        ack = !got;
    endtask
    task automatic stop_cond();
        tick(2);
        sda_low = 1'b1;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda_low = 1'b0;
        tick(HALF);
    endtask
endmodule

// [tb/smr_top_bench.sv]
// Purpose: Self-checking bench for the management bus slave
// Assumes: Strap and register file modelled here
// Notes: Short reset pulse parameter keeps the run small
`timescale 1ns/1ps
module smr_top_bench;
    import smr_pkg::*;
    localparam int PULSE = 20;
    logic sys_clk, reset, scl_in, sda_in, sda_out, sda_oe, sda_low;
    logic addr_pin_pu_in, addr_pin_pd_in, addr_pin_out, addr_pin_oe;
    logic rst_out_enable, rst_pulse_start, int_out_enable, limit_event;
    logic id4_digital_mode, id4_pin_in, core_volt_id_bit4, reg_wr_en;
    logic strap_done, strap_pu, strap_pd;
    logic [7:0] reg_ptr, reg_wr_data, reg_rd_data, wr_last, rx;
    logic [1:0] bus_addr_low;
    logic [3:0] acks;
    logic [6:0] dev;
    int errors, checks_done, wr_cnt, seed, hi;
    function automatic logic [7:0] rd_model(input logic [7:0] p);
        return p ^ 8'hA5;
    endfunction
    // Wired-AND bus and strap pin, both pulled when released
    assign sda_in = !(sda_low || (sda_oe && !sda_out));
    assign addr_pin_pu_in = strap_pu && !(addr_pin_oe && !addr_pin_out);
    assign addr_pin_pd_in = strap_pd && !(addr_pin_oe && !addr_pin_out);
    assign reg_rd_data = rd_model(reg_ptr);
    smr_top #(.RST_PULSE_CYC(PULSE)) uut (.*);
    smr_master_model mst (.sys_clk(sys_clk), .sda_line(sda_in),
        .scl(scl_in), .sda_low(sda_low));
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = !sys_clk;
    end
    // Data register writes as the register file would take them
    always @(posedge sys_clk)
        if (reg_wr_en === 1'b1)
        begin
            wr_cnt++;
            wr_last = reg_wr_data;
        end
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [6:0] a, input int n,
        input logic [7:0] b0, input logic [7:0] b1);
        logic k;
        acks = 4'h0;
        mst.start_cond();
        mst.xfer({a, SMR_DIR_WRITE}, rx, k);
        acks[0] = k;
        for (int i = 1; i <= n; i++)
        begin
            mst.xfer(i == 1 ? b0 : (i == 2 ? b1 : ~b1), rx, k);
            acks[i] = k;
        end
        mst.stop_cond();
    endtask
    task automatic rd(input logic [6:0] a);
        logic k;
        acks = 4'h0;
        mst.start_cond();
        mst.xfer({a, SMR_DIR_READ}, rx, k);
        acks[0] = k;
        mst.xfer(8'hFF, rx, k);
        mst.stop_cond();
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog: the whole sequence needs well under 30000 cycles
    initial
    begin
        #5_000_000;
        errors++;
        give_verdict();
    end
    initial
    begin
        seed = 80345;
        reset = 1'b1;
        {rst_out_enable, rst_pulse_start, int_out_enable, limit_event} = 4'h0;
        {id4_digital_mode, id4_pin_in, strap_pu, strap_pd} = 4'h7;
        repeat (3) @(negedge sys_clk);
        reset = 1'b0;
        repeat (6) @(negedge sys_clk);
        check("addr_low", bus_addr_low, SMR_STRAP_OPEN);
        check("ptr", reg_ptr, 8'h00);
        check("id4", core_volt_id_bit4, 1'b0);
        // Strap tied to supply, then grounded after the first start
        dev = {SMR_ADDR_FIXED, SMR_STRAP_VCC};
        wr(dev, 1, 8'h3C, 8'h00);
        check("acks", acks, 4'h3);
        check("ptr", reg_ptr, 8'h3C);
        check("writes", 8'(wr_cnt), 8'h00);
        check("addr_low", bus_addr_low, SMR_STRAP_VCC);
        strap_pu = 1'b0;
        strap_pd = 1'b0;
        rd(dev);
        check("ack", acks, 4'h1);
        check("read", rx, rd_model(8'h3C));
        $display("pointer test done");
        // Random pointer and data, top pointer value first
        for (int i = 0; i < 4; i++)
        begin
            hi = $random(seed);
            if (i == 0)
                hi[7:0] = 8'hFF;
            wr(dev, 2, hi[7:0], hi[15:8]);
            check("acks", acks, 4'h7);
            check("ptr", reg_ptr, hi[7:0]);
            check("wdata", wr_last, hi[15:8]);
            check("writes", 8'(wr_cnt), 8'(i + 1));
            rd(dev);
            check("read", rx, rd_model(hi[7:0]));
        end
        $display("random test done");
        wr({SMR_ADDR_FIXED, SMR_STRAP_OPEN}, 1, 8'h11, 8'h00);
        check("nack", acks, 4'h0);
        check("ptr", reg_ptr, hi[7:0]);
        wr(dev, 3, 8'h80, 8'h5C);
        check("acks", acks, 4'h7);
        check("writes", 8'(wr_cnt), 8'h05);
        check("wdata", wr_last, 8'h5C);
        $display("refusal test done");
        rst_out_enable = 1'b1;
        @(negedge sys_clk);
        rst_pulse_start = 1'b1;
        @(negedge sys_clk);
        rst_pulse_start = 1'b0;
        hi = 0;
        repeat (3 * PULSE) @(negedge sys_clk) hi += int'(addr_pin_oe === 1'b1);
        check("pulse", 8'(hi), 8'(PULSE));
        rst_out_enable = 1'b0;
        int_out_enable = 1'b1;
        limit_event = 1'b1;
        repeat (3) @(negedge sys_clk);
        check("int", addr_pin_oe, 1'b1);
        limit_event = 1'b0;
        repeat (2) @(negedge sys_clk);
        check("int", addr_pin_oe, 1'b0);
        id4_digital_mode = 1'b1;
        repeat (8) @(negedge sys_clk);
        check("id4", core_volt_id_bit4, 1'b1);
        $display("pin test done");
        // Power cycle with the strap grounded, then left open
        for (int s = 0; s < 2; s++)
        begin
            strap_pu = s[0];
            reset = 1'b1;
            repeat (3) @(negedge sys_clk);
            reset = 1'b0;
            repeat (6) @(negedge sys_clk);
            dev = {SMR_ADDR_FIXED, s[0] ? SMR_STRAP_OPEN : SMR_STRAP_GND};
            wr(dev, 1, 8'h42, 8'h00);
            check("acks", acks, 4'h3);
            check("addr_low", bus_addr_low, dev[1:0]);
        end
        // Pointer write, repeated start, then read in one frame
        mst.start_cond();
        mst.xfer({dev, SMR_DIR_WRITE}, rx, acks[0]);
        mst.xfer(8'h5A, rx, acks[1]);
        mst.start_cond();
        mst.xfer({dev, SMR_DIR_READ}, rx, acks[2]);
        mst.xfer(8'hFF, rx, acks[3]);
        mst.stop_cond();
        check("acks", acks, 4'h7);
        check("read", rx, rd_model(8'h5A));
        $display("reset test done");
        give_verdict();
    end
endmodule

// [tb/smr_top_chk.sv]
// Purpose: Port-level checks on the management bus slave
// Assumes: One clock domain, async active-high reset
// Notes: Bound into every smr_top instance
`timescale 1ns/1ps
module smr_top_chk
#(
    parameter int RST_PULSE_CYC = smr_pkg::SMR_RST_PULSE_CYC
)
(
    input wire logic sys_clk, // Clock
    input wire logic reset, // Reset
    input wire logic scl_in, // Bus clock
    input wire logic sda_oe, // Data pull enable
    input wire logic addr_pin_oe, // Strap pull enable
    input wire logic rst_out_enable, // Reset mode
    input wire logic rst_pulse_start, // Pulse request
    input wire logic int_out_enable, // Interrupt mode
    input wire logic limit_event, // Limit level
    input wire logic id4_digital_mode, // Id mode
    input wire logic core_volt_id_bit4, // Id bit
    input wire logic [smr_pkg::SMR_PTR_W-1:0] reg_ptr, // Pointer
    input wire logic reg_wr_en, // Write strobe
    input wire logic [1:0] bus_addr_low, // Strap bits
    input wire logic strap_done // Strap taken
);
    import smr_pkg::*;
    logic [17:0] run_q;
    logic [17:0] run_d;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Length of the current low stretch on the strap pin
    always_comb run_d = addr_pin_oe ? run_q + 18'h00001 : 18'h00000;
    always_ff @(posedge sys_clk or posedge reset)
        if (reset)
            run_q <= 18'h00000;
        else
            run_q <= run_d;
    // A pulse request only counts if the mode stays on while it launches
    sequence pulse_req;
        rst_out_enable && rst_pulse_start && !addr_pin_oe && !int_out_enable;
    endsequence
    sequence mode_held;
        rst_out_enable [*2];
    endsequence
    a_pulse_starts: assert property (
        pulse_req ##1 mode_held |-> addr_pin_oe)
        else $error("reset pulse late");
    a_pulse_length: assert property ($fell(addr_pin_oe)
        && rst_out_enable && !int_out_enable |-> run_q == RST_PULSE_CYC)
        else $error("reset pulse length wrong");
    a_int_mirror: assert property (!rst_out_enable
        && $past(!rst_out_enable, 2)
        |-> addr_pin_oe == $past(int_out_enable && limit_event))
        else $error("interrupt pin wrong");
    a_ack_scl_low: assert property (
        $changed(sda_oe) |-> !scl_in)
        else $error("data moved with clock high");
    a_id4_analog: assert property (
        $past(!id4_digital_mode) |-> !core_volt_id_bit4)
        else $error("id bit not zero");
    a_strap_frozen: assert property (
        strap_done |=> strap_done && $stable(bus_addr_low))
        else $error("strap changed");
    a_strap_default: assert property (
        !strap_done |-> bus_addr_low == SMR_STRAP_OPEN)
        else $error("strap default wrong");
    a_write_pulse: assert property (reg_wr_en |=> !reg_wr_en)
        else $error("write strobe too long");
    a_ptr_held_wr: assert property (
        reg_wr_en |-> $stable(reg_ptr))
        else $error("pointer moved on write");
endmodule

bind smr_top smr_top_chk #(.RST_PULSE_CYC(RST_PULSE_CYC)) chk (.sys_clk,
    .reset, .scl_in, .sda_oe, .addr_pin_oe, .rst_out_enable, .rst_pulse_start,
    .int_out_enable, .limit_event, .id4_digital_mode, .core_volt_id_bit4,
    .reg_ptr, .reg_wr_en, .bus_addr_low, .strap_done);
